/* File: src/pvc_params.svh */
// constants for the output voltage command bank
`ifndef PVC_PARAMS_SVH
`define PVC_PARAMS_SVH
`define PVC_CMD_VMODE 8'h20
`define PVC_CMD_VCMD 8'h21
`define PVC_CMD_VMAX 8'h24
`define PVC_CMD_MHIGH 8'h25
`define PVC_CMD_MLOW 8'h26
`define PVC_CMD_IOFS 8'h39
`define PVC_CMD_OVRESP 8'h41
`define PVC_CMD_UVRESP 8'h45
`define PVC_CMD_TBLSEL 8'hdd
`define PVC_MODE_VID 3'h1
`define PVC_PARAM_TBL2 5'h02
`define PVC_PARAM_TBL1 5'h01
`define PVC_RST_VMAX 8'hff
`define PVC_RST_MARGIN 8'h00
`define PVC_RST_IOFS 16'h0000
`define PVC_OV_RESP 8'h80
`define PVC_UV_RESP 8'hba
`define PVC_UV_DELAY_MS 22
`define PVC_CLK_HZ 40000000
`define PVC_UV_DELAY_CYC ((`PVC_UV_DELAY_MS * `PVC_CLK_HZ) / 1000)
`endif

/* File: src/pvc_pkg.sv */
// types for the output voltage command bank
package pvc_pkg;
  typedef enum logic [1:0] {PVC_RUN, PVC_OV_OFF, PVC_UV_WAIT} pvc_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } pvc_req_t;
  typedef struct packed {
    logic other;
    logic vout_ov;
    logic vout_word;
    logic vmax_warn;
    logic uv_fault;
    logic cml_data;
  } pvc_status_t;
endpackage : pvc_pkg

/* File: src/pvc_restart_timer.sv */
// restart delay counter after an undervoltage shutdown
`timescale 1ns/1ps
`include "pvc_params.svh"
module pvc_restart_timer #(
  parameter int unsigned DELAY_CYC = `PVC_UV_DELAY_CYC
) (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // sync reset, low
  input wire logic i_ce, // clock enable
  input wire logic i_start, // begin delay
  output logic o_done // one-cycle pulse at end
);
  logic [31:0] count;
  logic busy;
  // count down; restart mid-count simply reloads
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      count <= 32'h0;
      busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_start) begin
        count <= DELAY_CYC - 32'h1;
        busy <= 1'b1;
      end else if (busy) begin
        if (count == 32'h0) begin
          busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end
endmodule : pvc_restart_timer

/* File: src/pvc_bank.sv */
// output voltage command bank: registers, clamp and fault responses
//
// What this block does
// R1: mode byte reads VID code and table parameter
// R2: commanded voltage is right-justified VID code
// R3: VID table from strap pin or select command
// R4: commanded upper byte reads zero, lower writable
// R5: commanded voltage clamped to programmed maximum
// R6: over-maximum request is warning, output keeps regulating
// R7: over-maximum sets other, vout, warn, alert
// R8: maximum resets to 00ff, upper byte zero
// R9: margin high code, reset zero, used on select
// R10: margin low code, reset zero, used on select
// R11: current offset word, exponent and mantissa
// R12: overvoltage fault latches off, sets flags, alert
// R13: overvoltage response fixed, no restart
// R14: undervoltage fault sets other, vout, uv, alert
// R15: mode byte write rejected as data fault
// R16: undervoltage shuts down, restarts after delay
// R17: reserved upper-byte writes discarded
`timescale 1ns/1ps
`include "pvc_params.svh"
module pvc_bank #(
  parameter int unsigned UV_DELAY_CYC = `PVC_UV_DELAY_CYC
) (
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_nrst, // sync reset, low
  input wire logic i_ce, // clock enable
  input wire pvc_pkg::pvc_req_t i_req, // command read or write
  input wire logic [7:0] i_startup_voltage_code, // startup code
  input wire logic i_vid_table_strap_pin, // table strap pin
  input wire logic [1:0] i_op_margin, // 0 nominal, 1 low, 2 high
  input wire logic i_ov_detect, // overvoltage comparator pin
  input wire logic i_uv_detect, // undervoltage comparator pin
  input wire logic i_clear_faults, // clear fault pulse
  output logic [15:0] o_rdata, // read data
  output logic o_rvalid, // read data valid pulse
  output logic [7:0] o_target_vid, // code to regulate to
  output logic o_table2, // table 2 selected
  output logic o_output_enable, // regulator enabled
  output logic [15:0] o_current_offset, // offset calibration
  output pvc_pkg::pvc_status_t o_status, // sticky status flags
  output logic o_host_alert_output // alert to host, high
);
  import pvc_pkg::*;

  logic [7:0] vcmd;
  logic [7:0] vmax;
  logic [7:0] mhigh;
  logic [7:0] mlow;
  logic [15:0] iofs;
  logic tblsel_cmd;
  logic tblsel_valid;
  logic strap_q1, strap_q2;
  logic ov_q1, ov_q2, uv_q1, uv_q2;
  logic ov_prev, uv_prev;
  pvc_state_t state, next_state;
  logic uv_start, uv_done;
  logic over_max;
  logic [7:0] wr_code;

  // clamp a code to the ceiling
  function automatic logic [7:0] clamp(input logic [7:0] code, input logic [7:0] lim);
    clamp = (code > lim) ? lim : code;
  endfunction : clamp

  // pin synchronisers; first stage read only by second
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      strap_q1 <= 1'b0;
      strap_q2 <= 1'b0;
      ov_q1 <= 1'b0;
      ov_q2 <= 1'b0;
      uv_q1 <= 1'b0;
      uv_q2 <= 1'b0;
    end else if (i_ce) begin
      strap_q1 <= i_vid_table_strap_pin;
      strap_q2 <= strap_q1;
      ov_q1 <= i_ov_detect;
      ov_q2 <= ov_q1;
      uv_q1 <= i_uv_detect;
      uv_q2 <= uv_q1;
    end
  end

  // only the low byte of a vid word is kept
  assign wr_code = i_req.data[7:0]; // R17 R4 R2
  assign over_max = i_req.wr && (i_req.cmd == `PVC_CMD_VCMD) && (wr_code > vmax); // R5

  // vid voltage registers; startup code loaded one cycle after reset
  logic boot_pending;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      vcmd <= 8'h00;
      boot_pending <= 1'b1;
      vmax <= `PVC_RST_VMAX; // R8
      mhigh <= `PVC_RST_MARGIN; // R9
      mlow <= `PVC_RST_MARGIN; // R10
      iofs <= `PVC_RST_IOFS;
    end else if (i_ce) begin
      if (boot_pending) begin
        boot_pending <= 1'b0;
        vcmd <= clamp(i_startup_voltage_code, vmax);
      end else if (i_req.wr) begin
        if (i_req.cmd == `PVC_CMD_VCMD) begin
          vcmd <= clamp(wr_code, vmax); // R5 R6
        end else if (i_req.cmd == `PVC_CMD_VMAX) begin
          vmax <= wr_code; // R8
          vcmd <= clamp(vcmd, wr_code); // R5
        end else if (i_req.cmd == `PVC_CMD_MHIGH) begin
          mhigh <= wr_code; // R9
        end else if (i_req.cmd == `PVC_CMD_MLOW) begin
          mlow <= wr_code; // R10
        end else if (i_req.cmd == `PVC_CMD_IOFS) begin
          iofs <= i_req.data; // R11
        end
      end
    end
  end

  // table select command; strap rules until software writes one
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      tblsel_cmd <= 1'b0;
      tblsel_valid <= 1'b0;
    end else if (i_ce && i_req.wr && i_req.cmd == `PVC_CMD_TBLSEL) begin
      tblsel_cmd <= i_req.data[0]; // R3
      tblsel_valid <= 1'b1;
    end
  end

  // fault sequencing; ov latches, uv restarts after delay
  always_comb begin
    next_state = state;
    uv_start = 1'b0;
    case (state)
      PVC_RUN: begin
        if (ov_q2 && !ov_prev) begin
          next_state = PVC_OV_OFF; // R12 R13
        end else if (uv_q2 && !uv_prev) begin
          next_state = PVC_UV_WAIT; // R16
          uv_start = 1'b1;
        end
      end
      PVC_OV_OFF: begin
        if (i_clear_faults) begin
          next_state = PVC_RUN; // R13
        end
      end
      PVC_UV_WAIT: begin
        if (ov_q2 && !ov_prev) begin
          next_state = PVC_OV_OFF;
        end else if (uv_done) begin
          next_state = PVC_RUN; // R16
        end
      end
      default: next_state = PVC_RUN;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state <= PVC_RUN;
      ov_prev <= 1'b0;
      uv_prev <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      ov_prev <= ov_q2;
      uv_prev <= uv_q2;
    end
  end

  pvc_restart_timer #(
    .DELAY_CYC(UV_DELAY_CYC)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(uv_start),
    .o_done(uv_done)
  );

  // sticky status; an event in the clear cycle wins
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_status <= '0;
    end else if (i_ce) begin
      if (i_clear_faults) begin
        o_status <= '0;
      end
      if (over_max) begin
        o_status.other <= 1'b1; // R7
        o_status.vout_word <= 1'b1;
        o_status.vmax_warn <= 1'b1;
      end
      if (state != PVC_OV_OFF && next_state == PVC_OV_OFF) begin
        o_status.vout_ov <= 1'b1; // R12
        o_status.vout_word <= 1'b1;
      end
      if (uv_start) begin
        o_status.other <= 1'b1; // R14
        o_status.vout_word <= 1'b1;
        o_status.uv_fault <= 1'b1;
      end
      if (i_req.wr && i_req.cmd == `PVC_CMD_VMODE) begin
        o_status.cml_data <= 1'b1; // R15
      end
    end
  end

  // outputs registered; alert follows any sticky flag
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_target_vid <= 8'h00;
      o_table2 <= 1'b0;
      o_output_enable <= 1'b0;
      o_current_offset <= `PVC_RST_IOFS;
      o_host_alert_output <= 1'b0;
    end else if (i_ce) begin
      if (i_op_margin == 2'h2) begin
        o_target_vid <= clamp(mhigh, vmax); // R9 R5
      end else if (i_op_margin == 2'h1) begin
        o_target_vid <= clamp(mlow, vmax); // R10 R5
      end else begin
        o_target_vid <= vcmd; // R2
      end
      o_table2 <= tblsel_valid ? tblsel_cmd : strap_q2; // R3
      o_output_enable <= (next_state == PVC_RUN) && !boot_pending; // R6 R13 R16
      o_current_offset <= iofs; // R11
      o_host_alert_output <= |o_status; // R7 R12 R14
    end
  end

  // read mux; vid words return zero upper byte
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      if (i_req.cmd == `PVC_CMD_VMODE) begin
        o_rdata <= {8'h00, `PVC_MODE_VID, (o_table2 ? `PVC_PARAM_TBL2 : `PVC_PARAM_TBL1)}; // R1
      end else if (i_req.cmd == `PVC_CMD_VCMD) begin
        o_rdata <= {8'h00, vcmd}; // R4
      end else if (i_req.cmd == `PVC_CMD_VMAX) begin
        o_rdata <= {8'h00, vmax};
      end else if (i_req.cmd == `PVC_CMD_MHIGH) begin
        o_rdata <= {8'h00, mhigh};
      end else if (i_req.cmd == `PVC_CMD_MLOW) begin
        o_rdata <= {8'h00, mlow};
      end else if (i_req.cmd == `PVC_CMD_IOFS) begin
        o_rdata <= iofs;
      end else if (i_req.cmd == `PVC_CMD_OVRESP) begin
        o_rdata <= {8'h00, `PVC_OV_RESP}; // R13
      end else if (i_req.cmd == `PVC_CMD_UVRESP) begin
        o_rdata <= {8'h00, `PVC_UV_RESP}; // R16
      end else if (i_req.cmd == `PVC_CMD_TBLSEL) begin
        o_rdata <= {15'h0000, o_table2};
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

  // checks
  a_cmd_clamped: assert property (@(posedge i_mclk) disable iff (!i_nrst) vcmd <= vmax) // R5
    else $error("commanded code above ceiling");
  a_over_warns: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R7
    (i_ce && over_max && !i_clear_faults) |=> o_status.vmax_warn && o_status.other)
    else $error("over-maximum write not flagged");
  a_alert_follows: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R7
    (i_ce && o_status.vmax_warn) |=> o_host_alert_output)
    else $error("alert missing");
  a_ov_latched: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R13
    (state == PVC_OV_OFF && !i_clear_faults) |=> state == PVC_OV_OFF)
    else $error("overvoltage latch released");
  a_ov_disables: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
    (i_ce && state == PVC_OV_OFF && !i_clear_faults) |=> !o_output_enable)
    else $error("output on during overvoltage");
  a_uv_flags: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R14
    (i_ce && uv_start && !i_clear_faults) |=> o_status.uv_fault)
    else $error("undervoltage not flagged");
  a_mode_reject: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R15
    (i_ce && i_req.wr && i_req.cmd == `PVC_CMD_VMODE) |=> o_status.cml_data)
    else $error("mode write not rejected");
  a_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R17
    (i_ce && !boot_pending && i_req.wr && i_req.cmd == `PVC_CMD_MHIGH) |=> mhigh == $past(i_req.data[7:0]))
    else $error("reserved byte kept on write");

  // read path
  a_read_valid: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R4
    (i_ce && i_req.rd) |=> o_rvalid)
    else $error("read not answered");
  a_mode_code: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R1
    (i_ce && i_req.rd && i_req.cmd == `PVC_CMD_VMODE) |=> o_rdata[7:5] == `PVC_MODE_VID)
    else $error("mode code wrong");
  a_ov_resp_fixed: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R13
    (i_ce && i_req.rd && i_req.cmd == `PVC_CMD_OVRESP) |=> o_rdata == {8'h00, `PVC_OV_RESP})
    else $error("overvoltage response changed");
  a_uv_resp_fixed: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R16
    (i_ce && i_req.rd && i_req.cmd == `PVC_CMD_UVRESP) |=> o_rdata == {8'h00, `PVC_UV_RESP})
    else $error("undervoltage response changed");
  a_table_strap: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R3
    (i_ce && !tblsel_valid) |=> o_table2 == $past(strap_q2))
    else $error("table not taken from strap");
  a_table_cmd: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R3
    (i_ce && tblsel_valid) |=> o_table2 == $past(tblsel_cmd))
    else $error("table not taken from command");

  // voltage codes; the past ceiling is used since a write may lower it
  a_cmd_write: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R2
    (i_ce && !boot_pending && i_req.wr && i_req.cmd == `PVC_CMD_VCMD && wr_code <= vmax) |=> vcmd == $past(wr_code))
    else $error("commanded code not stored");
  a_vmax_lowers: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    (i_ce && !boot_pending && i_req.wr && i_req.cmd == `PVC_CMD_VMAX) |=> vcmd <= $past(wr_code))
    else $error("commanded code above new ceiling");
  a_margin_ceiling: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    (i_ce && i_op_margin == 2'h2) |=> o_target_vid <= $past(vmax))
    else $error("margin target above ceiling");
  a_warn_runs: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R6
    (i_ce && over_max && !boot_pending && next_state == PVC_RUN) |=> o_output_enable)
    else $error("over-maximum write stopped the output");

  // fault sequencing
  a_ov_status: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
    (i_ce && state != PVC_OV_OFF && next_state == PVC_OV_OFF) |=> o_status.vout_ov && o_status.vout_word)
    else $error("overvoltage not flagged");
  a_uv_off: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R16
    (i_ce && state == PVC_UV_WAIT && !uv_done) |=> !o_output_enable)
    else $error("output on during restart delay");
  a_uv_restart: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R16
    (i_ce && state == PVC_UV_WAIT && uv_done && !(ov_q2 && !ov_prev)) |=> o_output_enable)
    else $error("no restart after delay");
  a_alert_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
    (i_ce && o_status == '0) |=> !o_host_alert_output)
    else $error("alert without a flag");
  c_over_max: cover property (@(posedge i_mclk) over_max);
  c_ov_off: cover property (@(posedge i_mclk) state == PVC_OV_OFF);
  c_uv_restart: cover property (@(posedge i_mclk) state == PVC_UV_WAIT && uv_done);
  c_margin_high: cover property (@(posedge i_mclk) i_ce && i_op_margin == 2'h2);
  c_mode_write: cover property (@(posedge i_mclk) i_req.wr && i_req.cmd == `PVC_CMD_VMODE);
endmodule : pvc_bank

/* File: dv/pvc_host_model.sv */
// host side model issuing command reads and writes
`timescale 1ns/1ps
module pvc_host_model (
  input wire logic i_mclk, // bank clock
  input wire logic [15:0] i_rdata, // read data from bank
  input wire logic i_rvalid, // read data valid pulse
  output pvc_pkg::pvc_req_t o_req // request to bank
);
  import pvc_pkg::*;
  // idle request is all zero so no stray strobe after a transfer
  initial o_req = '0;
  // one-cycle write strobe, whole 16-bit word right-justified
  task automatic write(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge i_mclk);
    #1 o_req = '{wr: 1'b1, rd: 1'b0, cmd: cmd, data: data};
    @(posedge i_mclk);
    #1 o_req = '0;
  endtask : write
  // read answer lands with the registered valid pulse after the taking edge
  task automatic read(input logic [7:0] cmd, output logic [15:0] data, output logic vld);
    @(posedge i_mclk);
    #1 o_req = '{wr: 1'b0, rd: 1'b1, cmd: cmd, data: 16'h0000};
    @(posedge i_mclk);
    #1 o_req = '0;
    data = i_rdata;
    vld = i_rvalid;
  endtask : read
endmodule : pvc_host_model

/* File: dv/tb_top.sv */
// self-checking bench for the output voltage command bank
`timescale 1ns/1ps
`include "pvc_params.svh"
module tb_top;
  import pvc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] boot_code = 8'h00;
  logic strap = 1'b0;
  logic [1:0] margin_sel = 2'h0;
  logic ov_pin = 1'b0;
  logic uv_pin = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1; // dropped once to prove the freeze
  pvc_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  logic [7:0] target;
  logic table2;
  logic out_en;
  logic [15:0] cur_ofs;
  pvc_status_t status;
  logic alert;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 31764;
  localparam int UV_CYC = 20;
  // free-running 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;
  pvc_host_model host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  // short restart delay keeps the run brief
  pvc_bank #(.UV_DELAY_CYC(UV_CYC)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .i_req(req),
    .i_startup_voltage_code(boot_code), .i_vid_table_strap_pin(strap), .i_op_margin(margin_sel),
    .i_ov_detect(ov_pin), .i_uv_detect(uv_pin), .i_clear_faults(clr), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_target_vid(target), .o_table2(table2), .o_output_enable(out_en), .o_current_offset(cur_ofs),
    .o_status(status), .o_host_alert_output(alert));
  // expected mode byte for the selected table
  function automatic logic [15:0] exp_mode(input logic t2);
    return {8'h00, `PVC_MODE_VID, t2 ? `PVC_PARAM_TBL2 : `PVC_PARAM_TBL1};
  endfunction : exp_mode
  // vid words keep only the low byte
  function automatic logic [15:0] exp_vid(input logic [15:0] d);
    return {8'h00, d[7:0]};
  endfunction : exp_vid
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // read a command and compare data and valid pulse
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.read(cmd, d, v);
    chk_bit(v, 1'b1);
    chk_word(d, exp);
  endtask : rd_chk
  task automatic pulse_clear();
    @(posedge i_mclk);
    #1 clr = 1'b1;
    @(posedge i_mclk);
    #1 clr = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : pulse_clear
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(25 * 5000);
    miscompares++;
    complete_run();
  end
  initial begin
    static logic [7:0] cmds [6] = '{8'h24, 8'h25, 8'h26, 8'h39, 8'h41, 8'h45};
    static logic [15:0] rsts [6] = '{16'h00ff, 16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'h00ba};
    logic [15:0] d;
    logic v;
    logic [7:0] c;
    int k;
    boot_code = 8'($random(seed));
    repeat (10) @(posedge i_mclk);
    #1 i_nrst = 1'b1;
    repeat (2) @(posedge i_mclk);
    // reset values, fixed responses and startup load
    for (int i = 0; i < 6; i++) rd_chk(cmds[i], rsts[i]);
    rd_chk(8'h21, exp_vid({8'h00, boot_code}));
    $display("test reset_values done");
    // table choice from strap, then from select command which overrides it
    rd_chk(8'h20, exp_mode(1'b0));
    @(posedge i_mclk) #1 strap = 1'b1;
    repeat (4) @(posedge i_mclk);
    rd_chk(8'h20, exp_mode(1'b1));
    chk_bit(table2, 1'b1);
    @(posedge i_mclk) #1 strap = 1'b0;
    repeat (4) @(posedge i_mclk);
    rd_chk(8'h20, exp_mode(1'b0));
    host.write(8'hdd, 16'h0001);
    rd_chk(8'h20, exp_mode(1'b1));
    rd_chk(8'hdd, 16'h0001);
    $display("test table_select done");
    // refused writes: mode byte flags a data fault, responses stay fixed
    host.write(8'h20, 16'($random(seed)));
    host.write(8'h41, 16'($random(seed)));
    host.write(8'h45, 16'($random(seed)));
    rd_chk(8'h20, exp_mode(1'b1));
    rd_chk(8'h41, 16'h0080);
    rd_chk(8'h45, 16'h00ba);
    chk_bit(status.cml_data, 1'b1);
    pulse_clear();
    $display("test refused_writes done");
    // random words, reserved upper byte dropped on vid words
    for (int i = 0; i < 12; i++) begin
      c = cmds[1 + (i % 3)];
      d = 16'($random(seed));
      host.write(c, d);
      rd_chk(c, (c == 8'h39) ? d : exp_vid(d));
      if (c == 8'h39) chk_word(cur_ofs, d);
    end
    host.write(8'h21, 16'hff5a);
    rd_chk(8'h21, 16'h005a);
    $display("test random_words done");
    // margin selection picks the stored codes
    host.write(8'h25, 16'h0030);
    host.write(8'h26, 16'h0010);
    @(posedge i_mclk) #1 margin_sel = 2'h2;
    repeat (3) @(posedge i_mclk);
    chk_word({8'h00, target}, 16'h0030);
    #1 margin_sel = 2'h1;
    repeat (3) @(posedge i_mclk);
    chk_word({8'h00, target}, 16'h0010);
    #1 margin_sel = 2'h0;
    // enable low: write and read are lost, outputs hold their last value
    ce = 1'b0;
    host.write(8'h25, 16'h0077);
    host.read(8'h25, d, v);
    ce = 1'b1;
    chk_bit(v, 1'b0);
    chk_word({8'h00, target}, 16'h0010);
    rd_chk(8'h25, 16'h0030);
    $display("test margins done");
    // over-maximum request clamps and warns, output keeps running
    host.write(8'h24, 16'h0080);
    host.write(8'h21, 16'h00f0);
    repeat (2) @(posedge i_mclk);
    rd_chk(8'h21, 16'h0080);
    chk_word({8'h00, target}, 16'h0080);
    chk_bit(out_en, 1'b1);
    chk_word({10'h000, status}, 16'h002c);
    chk_bit(alert, 1'b1);
    host.write(8'h21, 16'h0080);
    pulse_clear();
    chk_bit(alert, 1'b0);
    $display("test clamp done");
    // overvoltage latches off until cleared
    ov_pin = 1'b1;
    // poll off the edge so the flag is looked at once it has settled
    for (k = 0; k < 10 && status.vout_ov !== 1'b1; k++) begin
      @(posedge i_mclk);
      #1;
    end
    repeat (2) @(posedge i_mclk);
    chk_word({10'h000, status}, 16'h0018);
    chk_bit(out_en, 1'b0);
    chk_bit(alert, 1'b1);
    #1 ov_pin = 1'b0;
    repeat (UV_CYC + 10) @(posedge i_mclk);
    chk_bit(out_en, 1'b0);
    pulse_clear();
    chk_bit(out_en, 1'b1);
    $display("test overvoltage done");
    // undervoltage shuts down then restarts after the delay
    uv_pin = 1'b1;
    for (k = 0; k < 10 && status.uv_fault !== 1'b1; k++) begin
      @(posedge i_mclk);
      #1;
    end
    repeat (2) @(posedge i_mclk);
    chk_word({10'h000, status}, 16'h002a);
    chk_bit(alert, 1'b1);
    chk_bit(out_en, 1'b0);
    #1 uv_pin = 1'b0;
    repeat (UV_CYC - 6) @(posedge i_mclk);
    chk_bit(out_en, 1'b0);
    for (k = 0; k < 12 && out_en !== 1'b1; k++) begin
      @(posedge i_mclk);
      #1;
    end
    chk_bit(out_en, 1'b1);
    $display("test undervoltage done");
    complete_run();
  end
endmodule : tb_top
